/* File: inc/cfs_pkg.sv */
// Constants and types of the converter fault sequencer
package cfs_pkg;

  // ****************************************
  // Clock and delay figures
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_INIT_NS     = 100000;
  localparam int T_ON_NS       = 50000;
  localparam int T_FAULT_NS    = 200000;
  localparam int INPUT_LOW_FILTER_TIME_NS     = 10000;
  localparam int INPUT_HIGH_FILTER_TIME_NS     = 5000;
  localparam int TMR_W         = 16;

  // Least times round up to whole cycles
  localparam logic [TMR_W-1:0] INIT_CYC  = TMR_W'((T_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] ON_CYC    = TMR_W'((T_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] FAULT_CYC = TMR_W'((T_FAULT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] INPUT_LOW_LOCKOUT_CYC  = TMR_W'((INPUT_LOW_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] INPUT_HIGH_LOCKOUT_CYC  = TMR_W'((INPUT_HIGH_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ****************************************
  // Monitor input positions
  // ****************************************
  localparam int SYNC_W    = 13;
  localparam int SI_EN     = 0;
  localparam int SI_UV_HI  = 1;
  localparam int SI_UV_LO  = 2;
  localparam int SI_OV_HI  = 3;
  localparam int SI_OV_LO  = 4;
  localparam int SI_INIT   = 5;
  localparam int SI_UVP    = 6;
  localparam int SI_OVP    = 7;
  localparam int SI_OTP    = 8;
  localparam int SI_FAST   = 9;
  localparam int SI_TICK   = 10;
  localparam int SI_LIGHT  = 11;
  localparam int SI_TRIM   = 12;

  // ****************************************
  // State types
  // ****************************************
  typedef enum logic [2:0] {CFS_OFF, CFS_INIT, CFS_IDLE, CFS_TON, CFS_RUN, CFS_HOLD,
                            CFS_WAIT} cfs_state_t;

  typedef struct packed {
    cfs_state_t st;
    logic       input_low_lockout_f;
    logic       input_high_lockout_f;
    logic       uvp_f;
    logic       otp_f;
    logic       ovp_f;
    logic       need_init;
    logic       trim_taken;
    logic       trim_active;
    logic       burst_off;
    logic       tick_prev;
    logic       ss_go;
  } cfs_regs_t;

  localparam cfs_regs_t CFS_REGS_RST = '{CFS_OFF, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                                         1'b0, 1'b0, 1'b0, 1'b0};

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] q;
  } cfs_sync_regs_t;

  localparam cfs_sync_regs_t CFS_SYNC_RST = '0;

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
  } cfs_tmr_regs_t;

  localparam cfs_tmr_regs_t CFS_TMR_RST = '0;

endpackage

/* File: inc/cfs_tmr_if.sv */
// Control and status bundle between the sequencer and one cycle timer
`timescale 1ns/10ps
interface cfs_tmr_if;
  import cfs_pkg::*;
  logic             clr;
  logic             run;
  logic [TMR_W-1:0] limit;
  logic             done;
  modport ctl (output clr, output run, output limit, input done);
  modport tmr (input clr, input run, input limit, output done);
endinterface

/* File: design/cfs_sync.sv */
// Three-stage synchroniser with agreement filter for the monitor inputs
`timescale 1ns/10ps
module cfs_sync
  import cfs_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  input  wire logic [SYNC_W-1:0] i_d,
  output logic      [SYNC_W-1:0] o_q
);

  cfs_sync_regs_t r_q;
  cfs_sync_regs_t r_d;

  // ****************************************
  // Next state
  // ****************************************
  // Output moves only when stages two and three agree
  always_comb
  begin
    r_d    = r_q;
    r_d.s1 = i_d;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    r_d.q  = (r_q.s2 & r_q.s3) | (r_q.q & (r_q.s2 | r_q.s3));
  end

  // Registers
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      r_q <= CFS_SYNC_RST;
    else
      r_q <= r_d;
  end

  assign o_q = r_q.q;

endmodule

/* File: design/cfs_timer.sv */
// Saturating cycle counter used for filters and sequencing delays
`timescale 1ns/10ps
module cfs_timer
  import cfs_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_resetn,
  cfs_tmr_if.tmr    tmr
);

  cfs_tmr_regs_t r_q;
  cfs_tmr_regs_t r_d;

  // Count while running, stop at the limit
  always_comb
  begin
    r_d = r_q;
    if (tmr.clr)
      r_d.cnt = '0;
    else if (tmr.run && !tmr.done)
      r_d.cnt = r_q.cnt + 1'b1;
  end

  // Registers
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      r_q <= CFS_TMR_RST;
    else
      r_q <= r_d;
  end

  assign tmr.done = (r_q.cnt >= tmr.limit);

endmodule

/* File: design/cfs_top.sv */
// Fault sequencer: gates the powertrain from enable and protection monitors
`timescale 1ns/10ps
module cfs_top
  import cfs_pkg::*;
#(
  parameter logic [TMR_W-1:0] P_INIT_CYC  = INIT_CYC,
  parameter logic [TMR_W-1:0] P_ON_CYC    = ON_CYC,
  parameter logic [TMR_W-1:0] P_FAULT_CYC = FAULT_CYC,
  parameter logic [TMR_W-1:0] P_INPUT_LOW_LOCKOUT_CYC  = INPUT_LOW_LOCKOUT_CYC,
  parameter logic [TMR_W-1:0] P_INPUT_HIGH_LOCKOUT_CYC  = INPUT_HIGH_LOCKOUT_CYC
)
(
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_enable,
  input  wire logic i_vin_above_input_low_lockout_rise,
  input  wire logic i_vin_below_input_low_lockout_fall,
  input  wire logic i_vin_above_input_high_lockout_rise,
  input  wire logic i_vin_below_input_high_lockout_fall,
  input  wire logic i_vin_above_init,
  input  wire logic i_vout_below_uvp,
  input  wire logic i_vout_above_ovp,
  input  wire logic i_temp_above_otp,
  input  wire logic i_fast_ov_stop,
  input  wire logic i_switch_cycle,
  input  wire logic i_light_load,
  input  wire logic i_setpoint_adjust_in,
  output logic      o_powertrain_en,
  output logic      o_soft_start_go,
  output logic      o_fault_indicator_out,
  output logic      o_trim_active,
  output logic      o_input_low_lockout,
  output logic      o_input_high_lockout,
  output logic      o_output_low_protection,
  output logic      o_output_high_protection,
  output logic      o_temp_fault
);

  // ****************************************
  // Monitor synchronisation
  // ****************************************
  logic [SYNC_W-1:0] mon_raw;
  logic [SYNC_W-1:0] mon;

  // Gather the asynchronous monitor flags
  always_comb
  begin
    mon_raw           = '0;
    mon_raw[SI_EN]    = i_enable;
    mon_raw[SI_UV_HI] = i_vin_above_input_low_lockout_rise;
    mon_raw[SI_UV_LO] = i_vin_below_input_low_lockout_fall;
    mon_raw[SI_OV_HI] = i_vin_above_input_high_lockout_rise;
    mon_raw[SI_OV_LO] = i_vin_below_input_high_lockout_fall;
    mon_raw[SI_INIT]  = i_vin_above_init;
    mon_raw[SI_UVP]   = i_vout_below_uvp;
    mon_raw[SI_OVP]   = i_vout_above_ovp;
    mon_raw[SI_OTP]   = i_temp_above_otp;
    mon_raw[SI_FAST]  = i_fast_ov_stop;
    mon_raw[SI_TICK]  = i_switch_cycle;
    mon_raw[SI_LIGHT] = i_light_load;
    mon_raw[SI_TRIM]  = i_setpoint_adjust_in;
  end

  cfs_sync u_sync
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_d      (mon_raw),
    .o_q      (mon)
  );

  // ****************************************
  // Timers
  // ****************************************
  cfs_tmr_if seq_t ();
  cfs_tmr_if uv_t ();
  cfs_tmr_if ov_t ();

  cfs_timer u_seq_tmr
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .tmr      (seq_t.tmr)
  );

  cfs_timer u_uv_tmr
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .tmr      (uv_t.tmr)
  );

  cfs_timer u_ov_tmr
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .tmr      (ov_t.tmr)
  );

  // ****************************************
  // Sequencer state
  // ****************************************
  cfs_regs_t r_q;
  cfs_regs_t r_d;
  logic      tick;
  logic      set_uv;
  logic      set_ov;
  logic      set_uvp;
  logic      set_otp;
  logic      set_ovp;
  logic      hold_fault;
  logic      new_fault;
  logic      all_clear;

  // Switching cycle edge
  assign tick = mon[SI_TICK] & ~r_q.tick_prev;

  // Input-low filter runs only while running below the lower level
  assign uv_t.run   = (r_q.st == CFS_RUN) & mon[SI_UV_LO];
  assign uv_t.clr   = ~uv_t.run;
  assign uv_t.limit = P_INPUT_LOW_LOCKOUT_CYC;

  // Input-high filter runs in every state once power is present
  assign ov_t.run   = (r_q.st != CFS_OFF) & mon[SI_OV_HI];
  assign ov_t.clr   = ~ov_t.run;
  assign ov_t.limit = P_INPUT_HIGH_LOCKOUT_CYC;

  // Fault detections
  assign set_uv  = (r_q.st == CFS_RUN) & uv_t.done;
  assign set_ov  = ov_t.done;
  assign set_uvp = (r_q.st == CFS_RUN) & mon[SI_UVP];
  assign set_otp = (r_q.st != CFS_OFF) & mon[SI_OTP];
  assign set_ovp = (r_q.st == CFS_RUN) & tick & mon[SI_OVP];
  assign hold_fault = set_uvp | set_otp;
  assign new_fault  = set_uv | set_ov | hold_fault | set_ovp;

  // Sequencing delay chosen by the current state
  always_comb
  begin
    unique case (r_q.st)
      CFS_INIT: seq_t.limit = P_INIT_CYC;
      CFS_TON:  seq_t.limit = P_ON_CYC;
      CFS_HOLD: seq_t.limit = P_FAULT_CYC;
      default:  seq_t.limit = P_INIT_CYC;
    endcase
  end

  assign seq_t.run = 1'b1;
  assign seq_t.clr = (r_d.st != r_q.st) | hold_fault;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    r_d           = r_q;
    r_d.ss_go     = 1'b0;
    r_d.tick_prev = mon[SI_TICK];

    // Recovery criteria clear first
    if (mon[SI_UV_HI])
      r_d.input_low_lockout_f = 1'b0;
    if (mon[SI_OV_LO])
      r_d.input_high_lockout_f = 1'b0;
    if (r_q.st == CFS_WAIT)
      r_d.uvp_f = 1'b0;
    if ((r_q.st == CFS_WAIT) && !mon[SI_OTP])
      r_d.otp_f = 1'b0;
    if (!mon[SI_EN] || !mon[SI_INIT])
      r_d.ovp_f = 1'b0;

    // New events win over the clears
    r_d.input_low_lockout_f = r_d.input_low_lockout_f | set_uv;
    r_d.input_high_lockout_f = r_d.input_high_lockout_f | set_ov;
    r_d.uvp_f  = r_d.uvp_f | set_uvp;
    r_d.otp_f  = r_d.otp_f | set_otp;
    r_d.ovp_f  = r_d.ovp_f | set_ovp;

    // Every flag clear, for the recovery check
    all_clear = ~(r_d.input_low_lockout_f | r_d.input_high_lockout_f | r_d.uvp_f | r_d.otp_f | r_d.ovp_f);

    // Burst gating follows the light-load demand per cycle
    if (tick)
      r_d.burst_off = mon[SI_LIGHT];

    // Main sequence
    unique case (r_q.st)
      CFS_OFF:
      begin
        if (mon[SI_INIT])
          r_d.st = CFS_INIT;
      end
      CFS_INIT:
      begin
        if (seq_t.done)
        begin
          // Trim mode is taken once per power application
          if (!r_q.trim_taken)
          begin
            r_d.trim_taken  = 1'b1;
            r_d.trim_active = mon[SI_TRIM];
          end
          r_d.st = CFS_IDLE;
        end
      end
      CFS_IDLE:
      begin
        // Enable counts only once input is above the upper level
        if (mon[SI_EN] && mon[SI_UV_HI] && !r_q.ovp_f)
          r_d.st = CFS_TON;
      end
      CFS_TON:
      begin
        if (!mon[SI_EN])
          r_d.st = CFS_IDLE;
        else if (seq_t.done)
        begin
          r_d.st    = CFS_RUN;
          r_d.ss_go = 1'b1;
        end
      end
      CFS_RUN:
      begin
        if (!mon[SI_EN])
          r_d.st = CFS_IDLE;
      end
      CFS_HOLD:
      begin
        if (seq_t.done)
          r_d.st = CFS_WAIT;
      end
      CFS_WAIT:
      begin
        // Every active fault must have recovered
        if (all_clear)
        begin
          r_d.st        = r_q.need_init ? CFS_INIT : CFS_IDLE;
          r_d.need_init = 1'b0;
        end
      end
    endcase

    // Fault entry overrides the sequence
    if (hold_fault)
    begin
      r_d.st        = CFS_HOLD;
      r_d.need_init = 1'b1;
    end
    else if (new_fault && (r_q.st != CFS_HOLD))
      r_d.st = CFS_WAIT;

    // Loss of input power ends everything, trim mode included
    if (!mon[SI_INIT])
    begin
      r_d.st          = CFS_OFF;
      r_d.input_low_lockout_f      = 1'b0;
      r_d.input_high_lockout_f      = 1'b0;
      r_d.uvp_f       = 1'b0;
      r_d.otp_f       = 1'b0;
      r_d.need_init   = 1'b0;
      r_d.trim_taken  = 1'b0;
      r_d.trim_active = 1'b0;
    end
  end

  // Registers
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      r_q <= CFS_REGS_RST;
    else
      r_q <= r_d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Switching gate with fast stop and burst gating
  assign o_powertrain_en = (r_q.st == CFS_RUN) & ~mon[SI_FAST] & ~r_q.burst_off;

  // Indicator active whenever not running, start-up included
  assign o_fault_indicator_out = (r_q.st != CFS_RUN);

  assign o_soft_start_go          = r_q.ss_go;
  assign o_trim_active            = r_q.trim_active;
  assign o_input_low_lockout      = r_q.input_low_lockout_f;
  assign o_input_high_lockout     = r_q.input_high_lockout_f;
  assign o_output_low_protection  = r_q.uvp_f;
  assign o_output_high_protection = r_q.ovp_f;
  assign o_temp_fault             = r_q.otp_f;

endmodule

/* File: tb/cfs_props.sv */
// Concurrent checks on the fault sequencer top ports
`timescale 1ns/10ps
module cfs_props
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_enable,
  input wire logic i_vin_above_init,
  input wire logic i_vin_below_input_low_lockout_fall,
  input wire logic i_vout_below_uvp,
  input wire logic i_temp_above_otp,
  input wire logic i_fast_ov_stop,
  input wire logic o_powertrain_en,
  input wire logic o_fault_indicator_out,
  input wire logic o_trim_active,
  input wire logic o_input_low_lockout,
  input wire logic o_output_low_protection,
  input wire logic o_output_high_protection,
  input wire logic o_temp_fault
);
  // ****************************************
  // Port relations
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  chk_stop_shows: assert property (o_fault_indicator_out |-> !o_powertrain_en)
    else $error("powertrain on while indicator active");
  chk_disable_shows: assert property (!i_enable [*6] |-> o_fault_indicator_out)
    else $error("indicator idle while disabled");
  chk_latch_blocks: assert property (o_output_high_protection |-> o_fault_indicator_out)
    else $error("running with output high latch set");
  chk_flag_stops: assert property ((o_input_low_lockout || o_output_low_protection ||
    o_temp_fault) |-> !o_powertrain_en)
    else $error("powertrain on with a fault flag set");
  chk_fast_halt: assert property (i_fast_ov_stop [*6] |-> !o_powertrain_en)
    else $error("fast stop did not halt switching");
  chk_power_loss: assert property (!i_vin_above_init [*7] |-> o_fault_indicator_out &&
    !o_trim_active && !o_output_high_protection)
    else $error("state kept after input power loss");
  chk_latch_holds: assert property ((i_enable && i_vin_above_init) [*8] ##0
    o_output_high_protection |=> o_output_high_protection)
    else $error("output high latch cleared while enabled");
  chk_short_stops: assert property ((i_vout_below_uvp && !o_fault_indicator_out) [*3]
    |-> ##[0:6] o_fault_indicator_out)
    else $error("output low did not stop the powertrain");
  chk_heat_flag: assert property ((i_temp_above_otp && i_vin_above_init) [*8]
    |-> o_temp_fault)
    else $error("temperature fault not registered");
  chk_dip_filter: assert property ($rose(o_input_low_lockout)
    |-> $past(i_vin_below_input_low_lockout_fall, 7))
    else $error("input low flag raised by a short dip");
endmodule

bind cfs_top cfs_props u_props (.i_clk(i_clk), .i_resetn(i_resetn), .i_enable(i_enable),
  .i_vin_above_init(i_vin_above_init), .i_vin_below_input_low_lockout_fall(i_vin_below_input_low_lockout_fall),
  .i_vout_below_uvp(i_vout_below_uvp), .i_temp_above_otp(i_temp_above_otp),
  .i_fast_ov_stop(i_fast_ov_stop), .o_powertrain_en(o_powertrain_en),
  .o_fault_indicator_out(o_fault_indicator_out), .o_trim_active(o_trim_active),
  .o_input_low_lockout(o_input_low_lockout), .o_temp_fault(o_temp_fault),
  .o_output_low_protection(o_output_low_protection),
  .o_output_high_protection(o_output_high_protection));

/* File: tb/cfs_host.sv */
// Host model: drives enable and counts fault indications
`timescale 1ns/10ps
module cfs_host
(
  input  wire logic i_clk,
  input  wire logic i_want_en,
  input  wire logic i_fault_indicator_out,
  output logic      o_enable,
  output int        o_fault_events
);
  logic ind_q = 1'b1;

  // Known levels at time zero
  initial
  begin
    o_enable = 1'b0;
    o_fault_events = 0;
  end

  // Enable moves just after the edge; indicator rises are counted
  always @(posedge i_clk)
  begin
    o_enable <= #1 i_want_en;
    ind_q <= i_fault_indicator_out;
    if (i_fault_indicator_out === 1'b1 && ind_q === 1'b0)
      o_fault_events <= o_fault_events + 1;
  end
endmodule

/* File: tb/cfs_top_test.sv */
// Self-checking bench of the fault sequencer
`timescale 1ns/10ps
module cfs_top_test;
  import cfs_pkg::*;
  localparam logic [TMR_W-1:0] T_INIT = 16'h0008;
  localparam logic [TMR_W-1:0] T_ON   = 16'h0004;
  localparam logic [TMR_W-1:0] T_FLT  = 16'h000A;
  logic i_clk = 1'b0, i_resetn = 1'b0, want_en = 1'b1, i_enable;
  logic uv_rise = 1'b0, uv_fall = 1'b0, ov_rise = 1'b0, ov_fall = 1'b1, pwr = 1'b1;
  logic output_low_protection = 1'b0, output_high_protection = 1'b0, otp = 1'b0, fast = 1'b0, sw = 1'b0, light = 1'b0;
  logic trim_in = 1'b1;
  logic en, ssg, ind, trim, lo_f, hi_f, uvp_f, ovp_f, otp_f;
  int   err_count = 0, n_tests = 0, fault_events;

  // Clock and units
  always #25 i_clk = ~i_clk;
  cfs_top #(.P_INIT_CYC(T_INIT), .P_ON_CYC(T_ON), .P_FAULT_CYC(T_FLT),
    .P_INPUT_LOW_LOCKOUT_CYC(16'h0006), .P_INPUT_HIGH_LOCKOUT_CYC(16'h0005)) uut (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_enable(i_enable), .i_vin_above_input_low_lockout_rise(uv_rise),
    .i_vin_below_input_low_lockout_fall(uv_fall), .i_vin_above_input_high_lockout_rise(ov_rise),
    .i_vin_below_input_high_lockout_fall(ov_fall), .i_vin_above_init(pwr), .i_vout_below_uvp(output_low_protection),
    .i_vout_above_ovp(output_high_protection), .i_temp_above_otp(otp), .i_fast_ov_stop(fast),
    .i_switch_cycle(sw), .i_light_load(light), .i_setpoint_adjust_in(trim_in),
    .o_powertrain_en(en), .o_soft_start_go(ssg), .o_fault_indicator_out(ind),
    .o_trim_active(trim), .o_input_low_lockout(lo_f), .o_input_high_lockout(hi_f),
    .o_output_low_protection(uvp_f), .o_output_high_protection(ovp_f), .o_temp_fault(otp_f));
  cfs_host u_host (.i_clk(i_clk), .i_want_en(want_en), .i_fault_indicator_out(ind),
    .o_enable(i_enable), .o_fault_events(fault_events));

  // ****************************************
  // Helpers
  // ****************************************
  task tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task chk(input bit ok, input string m);
    n_tests++;
    if (!ok)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task report_and_stop;
    $display("errors %0d in %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task wait_ind(input logic v, output int n);
    for (n = 0; n < 2000 && ind !== v; n++)
      tick(1);
    if (n == 2000)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: indicator wait timed out", $time);
      report_and_stop();
    end
  endtask

  task sw_pulse;
    sw = 1'b1;
    tick(4);
    sw = 1'b0;
    tick(6);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task s_start;
    int n;
    tick(40);
    chk(ind === 1'b1 && en === 1'b0, "enable taken below lockout");
    uv_rise = 1'b1;
    wait_ind(1'b0, n);
    chk(n >= T_ON && en === 1'b1, "start-up indication too short");
    chk(trim === 1'b1, "trim mode not sampled");
    chk(ssg === 1'b1, "no soft start pulse");
    tick(1);
    chk(ssg === 1'b0, "soft start pulse too long");
  endtask

  task s_dip;
    int n;
    uv_fall = 1'b1;
    tick(2);
    uv_fall = 1'b0;
    tick(20);
    chk(lo_f === 1'b0 && en === 1'b1, "short dip caused a fault");
    uv_fall = 1'b1;
    uv_rise = 1'b0;
    wait_ind(1'b1, n);
    tick(1);
    chk(lo_f === 1'b1 && en === 1'b0, "input low not registered");
    uv_fall = 1'b0;
    tick(30);
    chk(ind === 1'b1, "restart before input rose");
    uv_rise = 1'b1;
    wait_ind(1'b0, n);
    chk(en === 1'b1 && trim === 1'b1, "no restart after input low");
  endtask

  task s_input_high;
    int n;
    fast = 1'b1;
    tick(6);
    chk(en === 1'b0 && ind === 1'b0 && hi_f === 1'b0, "fast stop wrong");
    fast = 1'b0;
    tick(6);
    chk(en === 1'b1, "no resume after fast stop");
    ov_fall = 1'b0;
    ov_rise = 1'b1;
    wait_ind(1'b1, n);
    tick(1);
    chk(hi_f === 1'b1 && n >= 5, "input high fault wrong");
    ov_rise = 1'b0;
    tick(30);
    chk(ind === 1'b1, "restart before input fell");
    ov_fall = 1'b1;
    wait_ind(1'b0, n);
    chk(en === 1'b1 && hi_f === 1'b0, "no restart after input high");
  endtask

  task s_out_faults;
    int n;
    output_low_protection = 1'b1;
    wait_ind(1'b1, n);
    tick(1);
    chk(uvp_f === 1'b1, "output low fault missing");
    output_low_protection = 1'b0;
    wait_ind(1'b0, n);
    chk(n >= T_FLT + T_INIT + T_ON && ssg === 1'b1, "output low recovery too fast");
    otp = 1'b1;
    output_low_protection = 1'b1;
    tick(T_FLT + 20);
    output_low_protection = 1'b0;
    chk(ind === 1'b1 && otp_f === 1'b1, "hot restart");
    otp = 1'b0;
    wait_ind(1'b0, n);
    chk(n >= T_INIT + T_ON && trim === 1'b1, "cool recovery wrong");
  endtask

  task s_ovp;
    int n;
    output_high_protection = 1'b1;
    tick(8);
    chk(ovp_f === 1'b0 && en === 1'b1, "output high taken between cycles");
    sw_pulse();
    chk(ovp_f === 1'b1 && en === 1'b0, "output high not caught");
    output_high_protection = 1'b0;
    tick(40);
    chk(ind === 1'b1 && ovp_f === 1'b1, "latch lost or restart");
    want_en = 1'b0;
    tick(10);
    chk(ovp_f === 1'b0, "latch kept after disable");
    want_en = 1'b1;
    wait_ind(1'b0, n);
    output_high_protection = 1'b1;
    sw_pulse();
    output_high_protection = 1'b0;
    pwr = 1'b0;
    uv_rise = 1'b0;
    trim_in = 1'b0;
    tick(10);
    chk(ovp_f === 1'b0 && trim === 1'b0, "power loss kept state");
    pwr = 1'b1;
    uv_rise = 1'b1;
    wait_ind(1'b0, n);
    chk(n >= T_INIT + T_ON && trim === 1'b0, "power-up after loss wrong");
  endtask

  task s_burst;
    int ev;
    trim_in = 1'b1;
    light = 1'b1;
    sw_pulse();
    chk(en === 1'b0 && ind === 1'b0, "no burst off");
    light = 1'b0;
    sw_pulse();
    chk(en === 1'b1, "no burst on");
    ev = fault_events;
    want_en = 1'b0;
    tick(10);
    chk(ind === 1'b1 && en === 1'b0 && fault_events == ev + 1, "disable");
    chk(trim === 1'b0, "trim resampled");
  endtask

  // Main sequence
  initial
  begin
    tick(6);
    i_resetn = 1'b1;
    s_start();
    s_dip();
    s_input_high();
    s_out_faults();
    s_ovp();
    s_burst();
    report_and_stop();
  end
endmodule
